//--- src/wdt_top.sv
// Watchdog timer with option-selected fixed or stoppable mode
`timescale 1ns/1ps
`include "wdt_defines.svh"
`default_nettype none
module wdt_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Option byte: 1 = low-speed oscillator cannot be stopped
  input wire logic opt_fixed_i,
  // Oscillator pins (asynchronous)
  input wire logic low_speed_osc_clock_i,
  input wire logic system_osc_clock_i,
  // CPU power state and settle status
  input wire logic halt_i,
  input wire logic stop_i,
  input wire logic osc_settle_busy_i,
  // Register access
  input wire logic mode_wr_i,
  input wire logic restart_wr_i,
  input wire logic bit_op_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] mode_rdata_o,
  output logic [7:0] restart_rdata_o,
  // Status
  output logic counting_o,
  output logic [`WDT_CNT_W-1:0] count_o,
  output logic internal_reset_o
);
  import wdt_pkg::*;

  // ==========================================================
  // Clock tick recovery
  // ==========================================================
  logic [1:0] osc_sync;
  logic [1:0] osc_tick;
  logic low_tick;
  logic sys_tick;

  wdt_sync #(.W(2)) u_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .d_i({system_osc_clock_i, low_speed_osc_clock_i}),
    .q_o(osc_sync)
  );

  // One edge detector per oscillator: bit 0 low-speed, bit 1 system
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_osc
      wdt_edge u_edge (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .level_i(osc_sync[g]),
        .tick_o(osc_tick[g])
      );
    end
  endgenerate

  assign low_tick = osc_tick[0];
  assign sys_tick = osc_tick[1];

  // ==========================================================
  // Mode register
  // ==========================================================
  logic [7:0] mode_reg;
  logic written_reg;
  logic stopped_first_reg;
  logic mode_first;
  logic mode_second;
  logic key_ok;
  logic restart_bad;

  // Only a full byte write counts as the one allowed configuration
  assign mode_first = mode_wr_i && !written_reg && !bit_op_i;
  assign mode_second = mode_wr_i && written_reg;
  assign key_ok = restart_wr_i && !bit_op_i && (wdata_i == `WDT_RESTART_KEY);
  assign restart_bad = restart_wr_i && (bit_op_i || (wdata_i != `WDT_RESTART_KEY));

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      mode_reg <= `WDT_MODE_RESET;
    end else if (mode_first) begin
      if (opt_fixed_i) begin
        // Source bits forced to the low-speed code
        mode_reg <= {wdata_i[7:5], 2'h0, wdata_i[2:0]};
      end else begin
        mode_reg <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      written_reg <= 1'b0;
    end else if (mode_first) begin
      written_reg <= 1'b1;
    end
  end

  // Later misuse is harmless only if the first write stopped counting
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      stopped_first_reg <= 1'b0;
    end else if (mode_first && !opt_fixed_i) begin
      stopped_first_reg <= wdata_i[`WDT_SRC_MSB];
    end
  end

  // ==========================================================
  // Clock source and period
  // ==========================================================
  logic [1:0] src_field;
  wdt_src_t src;
  logic [2:0] period;
  logic tick;
  logic [4:0] exp_val;

  assign src_field = mode_reg[`WDT_SRC_MSB:`WDT_SRC_LSB];
  assign period = mode_reg[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB];

  always_comb begin
    if (opt_fixed_i) begin
      src = SRC_LOW;
    end else begin
      unique casez (src_field)
        2'b00: src = SRC_LOW;
        2'b01: src = SRC_SYS;
        2'b1?: src = SRC_STOP;
      endcase
    end
  end

  // Stopped source gives no ticks at all
  always_comb begin
    unique case (src)
      SRC_LOW: tick = low_tick;
      SRC_SYS: tick = sys_tick;
      default: tick = 1'b0;
    endcase
  end

  always_comb begin
    if (src == SRC_SYS) begin
      exp_val = 5'(`WDT_SYS_EXP_BASE + period);
    end else begin
      exp_val = 5'(`WDT_LOW_EXP_BASE + period);
    end
  end

  // ==========================================================
  // Power-state sequencing
  // ==========================================================
  wdt_state_t state_reg;
  logic [`WDT_RESUME_W-1:0] resume_cnt_reg;
  logic stop_rel_sys_reg;
  logic sleep;
  logic resume_done;

  assign sleep = halt_i | stop_i;
  assign resume_done = (resume_cnt_reg == `WDT_RESUME_W'(`WDT_RESUME_CYC - 1));

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_reg <= RUN;
    end else begin
      unique case (state_reg)
        RUN: begin
          // Fixed mode never leaves this state
          if (sleep && !opt_fixed_i) begin
            state_reg <= FROZEN;
          end
        end
        FROZEN: begin
          if (!sleep) begin
            if (stop_rel_sys_reg) begin
              state_reg <= SETTLE;
            end else begin
              state_reg <= RUN;
            end
          end
        end
        SETTLE: begin
          if (!osc_settle_busy_i) begin
            state_reg <= RESUME;
          end
        end
        RESUME: begin
          if (resume_done) begin
            state_reg <= RUN;
          end
        end
      endcase
    end
  end

  // Counts the fixed pause once the oscillator has settled
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      resume_cnt_reg <= '0;
    end else if (state_reg != RESUME) begin
      resume_cnt_reg <= '0;
    end else if (!resume_done) begin
      resume_cnt_reg <= resume_cnt_reg + 1'b1;
    end
  end

  // Remember whether the sleep was a STOP with system clock source
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      stop_rel_sys_reg <= 1'b0;
    end else if (state_reg == RUN && sleep) begin
      stop_rel_sys_reg <= stop_i && (src == SRC_SYS);
    end
  end

  // ==========================================================
  // Counter and overflow
  // ==========================================================
  logic run_en;
  logic [`WDT_CNT_W-1:0] cnt_reg;
  logic [`WDT_CNT_W-1:0] limit;
  logic overflow;
  logic misuse;

  // Fixed mode: never frozen, never stopped
  always_comb begin
    if (opt_fixed_i) begin
      run_en = 1'b1;
    end else begin
      unique case (state_reg)
        RUN: run_en = !sleep && (src != SRC_STOP);
        FROZEN: run_en = 1'b0;
        SETTLE: run_en = 1'b0;
        RESUME: run_en = 1'b0;
      endcase
    end
  end

  assign limit = `WDT_CNT_W'(({`WDT_CNT_W{1'b1}} >> (`WDT_CNT_W - exp_val)));
  assign overflow = run_en && tick && (cnt_reg == limit);
  assign misuse = !stopped_first_reg && (restart_bad || mode_second);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cnt_reg <= '0;
    end else if (mode_first || key_ok) begin
      cnt_reg <= '0;
    end else if (overflow) begin
      // Wrap so an unserviced request comes back a full period later
      cnt_reg <= '0;
    end else if (run_en && tick) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // ==========================================================
  // Internal reset request
  // ==========================================================
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      internal_reset_o <= 1'b0;
    end else begin
      internal_reset_o <= overflow || misuse;
    end
  end

  // ==========================================================
  // Read-back and status
  // ==========================================================
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      mode_rdata_o <= `WDT_MODE_RESET;
    end else begin
      mode_rdata_o <= mode_reg;
    end
  end

  // Restart register always reads back the fixed pattern
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      restart_rdata_o <= `WDT_RESTART_READ;
    end else begin
      restart_rdata_o <= `WDT_RESTART_READ;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      counting_o <= 1'b0;
    end else begin
      counting_o <= run_en;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      count_o <= '0;
    end else begin
      count_o <= cnt_reg;
    end
  end
endmodule : wdt_top
`default_nettype wire

//--- shared/wdt_defines.svh
// Constants for the watchdog timer block
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH
`define WDT_MODE_RESET 8'h67
`define WDT_RESTART_READ 8'h9A
`define WDT_RESTART_KEY 8'hAC
`define WDT_PERIOD_LSB 0
`define WDT_PERIOD_MSB 2
`define WDT_SRC_LSB 3
`define WDT_SRC_MSB 4
`define WDT_LOW_EXP_BASE 11
`define WDT_SYS_EXP_BASE 13
`define WDT_CNT_W 21
`define WDT_RESUME_NS 34000
`define WDT_CLK_NS 20
`define WDT_RESUME_CYC ((`WDT_RESUME_NS) / (`WDT_CLK_NS))
`define WDT_RESUME_W 11
`endif

//--- shared/wdt_pkg.sv
// Types for the watchdog timer block
package wdt_pkg;
  typedef enum logic [1:0] {
    SRC_LOW = 2'h0,
    SRC_SYS = 2'h1,
    SRC_STOP = 2'h2
  } wdt_src_t;
  typedef enum logic [1:0] {
    RUN = 2'h0,
    FROZEN = 2'h1,
    SETTLE = 2'h3,
    RESUME = 2'h2
  } wdt_state_t;
endpackage : wdt_pkg

//--- src/wdt_sync.sv
// Two-stage synchroniser per bit
`timescale 1ns/1ps
`default_nettype none
module wdt_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
          meta_reg[g] <= 1'b0;
          q_o[g] <= 1'b0;
        end else begin
          meta_reg[g] <= d_i[g];
          q_o[g] <= meta_reg[g];
        end
      end
    end
  endgenerate
endmodule : wdt_sync
`default_nettype wire

//--- src/wdt_edge.sv
// Rising-edge detector giving one-cycle tick
`timescale 1ns/1ps
`default_nettype none
module wdt_edge (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic level_i,
  output logic tick_o
);
  logic last_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      last_reg <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      last_reg <= level_i;
      tick_o <= level_i & ~last_reg;
    end
  end
endmodule : wdt_edge
`default_nettype wire

//--- verification/wdt_chk.sv
// Watchdog port checker
`timescale 1ns/1ps
`include "wdt_defines.svh"
`default_nettype none
module wdt_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Inputs seen
  input wire logic opt_fixed_i,
  input wire logic halt_i,
  input wire logic mode_wr_i,
  input wire logic restart_wr_i,
  input wire logic bit_op_i,
  input wire logic [7:0] wdata_i,
  // Outputs seen
  input wire logic [7:0] mode_rdata_o,
  input wire logic [7:0] restart_rdata_o,
  input wire logic counting_o,
  input wire logic [`WDT_CNT_W-1:0] count_o,
  input wire logic internal_reset_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // ==========
  // Properties
  property p_rd; restart_rdata_o == 8'h9A; endproperty
  a_rd: assert property (p_rd) else $error("restart read bad");
  property p_key;
    restart_wr_i && !bit_op_i && wdata_i == 8'hAC |=> !internal_reset_o ##1 count_o < 21'h4;
  endproperty
  a_key: assert property (p_key) else $error("restart key bad");
  property p_badkey;
    opt_fixed_i && restart_wr_i && (bit_op_i || wdata_i != 8'hAC) |=> internal_reset_o;
  endproperty
  a_badkey: assert property (p_badkey) else $error("no reset");
  property p_src; opt_fixed_i |-> mode_rdata_o[4:3] == 2'b00; endproperty
  a_src: assert property (p_src) else $error("source stored");
  property p_run; opt_fixed_i && $past(resetn_i, 3) |-> counting_o; endproperty
  a_run: assert property (p_run) else $error("fixed stopped");
  property p_clr; mode_wr_i && !bit_op_i && mode_rdata_o == 8'h67 |-> ##2 count_o < 21'h4;
  endproperty
  a_clr: assert property (p_clr) else $error("not cleared");
  property p_frz; (!opt_fixed_i && halt_i)[*5] |-> $stable(count_o); endproperty
  a_frz: assert property (p_frz) else $error("halt counts");
  property p_off;
    !opt_fixed_i && mode_rdata_o[4] && (mode_wr_i || restart_wr_i) |=> !internal_reset_o;
  endproperty
  a_off: assert property (p_off) else $error("reset when off");
  c_rst: cover property (internal_reset_o);
  c_halt: cover property (halt_i && !opt_fixed_i);
  c_off: cover property (!counting_o && mode_rdata_o[4]);
endmodule : wdt_chk
`default_nettype wire

//--- verification/watchdog_mode_operation_tb.sv
// Watchdog self-checking testbench
`timescale 1ns/1ps
`include "wdt_defines.svh"
`default_nettype none
module watchdog_mode_operation_tb;
  logic clk_sys_i = 0, resetn_i = 0, opt_fixed_i = 1, low_i = 0, sys_i = 0;
  logic halt_i = 0, stop_i = 0, busy_i = 0, mode_wr_i = 0, restart_wr_i = 0, bit_op_i = 0;
  logic [7:0] wdata_i = 8'h00, mode_rdata_o, restart_rdata_o;
  logic counting_o, internal_reset_o;
  logic [`WDT_CNT_W-1:0] count_o, c;
  int bad_count = 0, samples_checked = 0, rsts = 0;
  wdt_top dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .opt_fixed_i(opt_fixed_i),
    .low_speed_osc_clock_i(low_i), .system_osc_clock_i(sys_i), .halt_i(halt_i),
    .stop_i(stop_i), .osc_settle_busy_i(busy_i), .mode_wr_i(mode_wr_i),
    .restart_wr_i(restart_wr_i), .bit_op_i(bit_op_i), .wdata_i(wdata_i),
    .mode_rdata_o(mode_rdata_o), .restart_rdata_o(restart_rdata_o),
    .counting_o(counting_o), .count_o(count_o), .internal_reset_o(internal_reset_o));
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #7;
    forever #40 low_i = ~low_i;
  end
  initial begin
    #13;
    forever #40 sys_i = ~sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (internal_reset_o === 1'b1) rsts++;
  end
  // ==========
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask : cyc
  task automatic rst(input logic f);
    resetn_i = 0;
    opt_fixed_i = f;
    cyc(12);
    resetn_i = 1;
    rsts = 0;
    cyc(3);
  endtask : rst
  task automatic wr(input logic m, input logic [7:0] d, input logic b);
    cyc(1);
    mode_wr_i = m;
    restart_wr_i = !m;
    wdata_i = d;
    bit_op_i = b;
    cyc(1);
    mode_wr_i = 0;
    restart_wr_i = 0;
    bit_op_i = 0;
  endtask : wr
  task automatic check(input string n, input logic [20:0] e, input logic [20:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s: expected %0h, seen %0h", n, e, g);
    end
  endtask : check
  task automatic results();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    cyc(60000);
    bad_count++;
    results();
  end
  // ==========
  // Tests
  initial begin
    rst(1);
    check("restart read", 8'h9A, restart_rdata_o);
    check("mode reset", 8'h67, mode_rdata_o);
    cyc(20);
    check("runs", 1, count_o != 0);
    wr(1, 8'h78, 0);
    cyc(2);
    check("mode", 8'h60, mode_rdata_o);
    check("counting", 1, counting_o);
    check("cleared", 1, count_o < 4);
    stop_i = 1;
    cyc(40);
    check("stop runs", 1, count_o > 4);
    wr(0, 8'hAC, 0);
    cyc(2);
    check("restart", 1, count_o < 4);
    cyc(8100);
    check("early", 0, rsts);
    cyc(200);
    check("overflow", 1, rsts);
    stop_i = 0;
    wr(1, 8'h61, 0);
    cyc(3);
    check("second", 2, rsts);
    wr(0, 8'h12, 0);
    cyc(3);
    check("bad key", 3, rsts);
    wr(0, 8'hAC, 1);
    cyc(3);
    check("bit op", 4, rsts);
    $display("test fixed done");
    rst(0);
    wr(1, 8'h70, 0);
    cyc(3);
    check("off", 0, counting_o);
    wr(1, 8'h68, 0);
    wr(0, 8'h12, 0);
    wr(0, 8'hAC, 1);
    cyc(3);
    check("quiet", 0, rsts);
    $display("test stopped done");
    rst(0);
    wr(1, 8'h68, 0);
    cyc(40);
    check("sys runs", 1, count_o > 4);
    halt_i = 1;
    cyc(3);
    c = count_o;
    cyc(40);
    check("halt", c, count_o);
    halt_i = 0;
    cyc(20);
    check("held", 1, count_o > c && count_o < c + 20);
    stop_i = 1;
    busy_i = 1;
    cyc(3);
    c = count_o;
    cyc(20);
    stop_i = 0;
    cyc(100);
    check("settle", c, count_o);
    busy_i = 0;
    cyc(1650);
    check("pause", c, count_o);
    cyc(100);
    check("resume", 1, count_o > c);
    $display("test sleep done");
    results();
  end
endmodule : watchdog_mode_operation_tb
bind wdt_top wdt_chk chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .opt_fixed_i(opt_fixed_i), .halt_i(halt_i), .mode_wr_i(mode_wr_i),
  .restart_wr_i(restart_wr_i), .bit_op_i(bit_op_i), .wdata_i(wdata_i),
  .mode_rdata_o(mode_rdata_o), .restart_rdata_o(restart_rdata_o),
  .counting_o(counting_o), .count_o(count_o), .internal_reset_o(internal_reset_o));
`default_nettype wire
